//--- core/dopot_pkg.sv
/*
 * Shared constants and types of the dual potentiometer two-wire target.
 * Assumes nothing of its surroundings; used by every design file.
 */
package dopot_pkg;
	////////////////////////////////////////////////////////////////////////////
	// Addressing
	localparam logic [6:0] ADDR_FIXED = 7'h2f;
	localparam logic [4:0] ADDR_UPPER = 5'h0b;
	////////////////////////////////////////////////////////////////////////////
	// Reset and preset values
	localparam logic [7:0] WIPER_MID = 8'h80;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [5:0] VALID_PAD = 6'h00;
	////////////////////////////////////////////////////////////////////////////
	// Bit counter values within one nine-pulse byte
	localparam logic [3:0] CNT_RST = 4'h0;
	localparam logic [3:0] CNT_ACK = 4'h8;
	localparam logic [3:0] CNT_DONE = 4'h9;
	localparam logic [3:0] CNT_ONE = 4'h1;
	////////////////////////////////////////////////////////////////////////////
	// Instruction byte field positions
	localparam int IB_SEL = 7;
	localparam int IB_SD = 6;
	localparam int IB_OTP = 5;
	localparam int IB_OW = 3;
	////////////////////////////////////////////////////////////////////////////
	// Fuse status codes {fuse_status_high, fuse_status_low}
	localparam logic [1:0] FUSE_READY = 2'h0;
	localparam logic [1:0] FUSE_FAIL = 2'h2;
	localparam logic [1:0] FUSE_DONE = 2'h3;
	////////////////////////////////////////////////////////////////////////////
	// Synchroniser width: scl, sda, rise toggle, two straps
	localparam int SYNC_W = 5;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_INSTR = 3'b010,
		ST_WDATA = 3'b011,
		ST_RDATA = 3'b100
	} dopot_state_t;
endpackage : dopot_pkg

//--- core/dopot_sync_if.sv
/*
 * Carrier between the target logic and its input synchroniser.
 * Assumes raw is driven by the user and sync by the synchroniser.
 */
interface dopot_sync_if #(parameter int W = dopot_pkg::SYNC_W) ();
	logic [W-1:0] raw;
	logic [W-1:0] sync;
	modport src (output raw, input sync);
	modport dst (input raw, output sync);
endinterface : dopot_sync_if

//--- core/dopot_sync.sv
/*
 * Two-stage synchroniser for a group of asynchronous levels.
 * Assumes each raw bit is a slowly changing level or a toggle.
 */
module dopot_sync #(
	parameter int W = dopot_pkg::SYNC_W
) (
	input wire logic clk,
	input wire logic rstn,
	dopot_sync_if.dst sb
);
	import dopot_pkg::*;
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	if (W < 1) begin : g_chk
		$error("dopot_sync: width must be at least one");
	end
	// First stage feeds only the second
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= sb.raw;
			s2_q <= s1_q;
		end
	end
	assign sb.sync = s2_q;
endmodule : dopot_sync

//--- core/dopot_target.sv
/*
 * Two-wire target of a dual 256-step one-time-programmable potentiometer.
 * Assumes scl_clk is the bus clock line (standing still between frames),
 * sda_i the bus data level, and a fuse array on the core clock.
 */
// Overview of operation
// - Data falling while clock high starts a transfer; next byte is address.
// - Address byte: seven address bits, then direction bit, high means read.
// - Fixed address, or upper five fixed and lowest two from strap pins.
// - On match drive data low in ninth pulse; otherwise stay idle, undriven.
// - Write: second byte is instruction; top bit selects channel one or two.
// - Second bit requests shutdown; stored wiper value is left untouched.
// - Writes during shutdown are stored; release applies the current value.
// - Third bit blows fuses, keeping the current wiper setting permanently.
// - Fifth bit overrides fuses; dropping it restores the earlier setting.
// - Override is volatile; power-up presets midscale or the fused value.
// - Lowest three instruction bits are ignored.
// - After instruction, data byte MSB first loads the selected wiper, acked.
// - Nine pulses per byte; data changes only while clock is low.
// - Read: wiper byte after address ack, then fuse status byte.
// - Status pair: 00 ready, 10 fatal error, 11 programmed.
// - Reads return the channel last selected by a write.
// - Data rising while clock high stops; partial transfer is dropped.
// - Controller not-acknowledge after a read byte makes the device release.
// - Further data bytes rewrite the wiper; repeated read bytes allowed.
module dopot_target #(
	parameter bit USE_STRAPS = 1'b0,
	parameter logic [6:0] FIXED_ADDR = dopot_pkg::ADDR_FIXED
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic scl_clk,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic strap_addr_bit1,
	input wire logic strap_addr_bit0,
	input wire logic fuse_status_high,
	input wire logic fuse_status_low,
	input wire logic [7:0] fused_setting_ch1,
	input wire logic [7:0] fused_setting_ch2,
	output logic fuse_prog,
	output logic [7:0] fuse_prog_value_ch1,
	output logic [7:0] fuse_prog_value_ch2,
	output logic [7:0] variable_resistor_setting_ch1,
	output logic [7:0] variable_resistor_setting_ch2,
	output logic shutdown_ch1,
	output logic shutdown_ch2,
	output logic [1:0] fuse_state
);
	import dopot_pkg::*;

	if (FIXED_ADDR[6:2] != ADDR_UPPER) begin : g_chk
		$error("dopot_target: fixed address must share the strap variant upper bits");
	end
	////////////////////////////////////////////////////////////////////////////
	// Link domain: sample data at each rising bus clock, flag it by a toggle
	logic rise_tgl_q, link_bit_q;
	always_ff @(posedge scl_clk or negedge rstn) begin
		if (!rstn) begin
			rise_tgl_q <= 1'b0;
			link_bit_q <= 1'b0;
		end else begin
			rise_tgl_q <= ~rise_tgl_q;
			link_bit_q <= sda_i;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Crossing into the core domain
	dopot_sync_if #(.W(SYNC_W)) sync_bus ();
	assign sync_bus.raw = {scl_clk, sda_i, rise_tgl_q, strap_addr_bit1, strap_addr_bit0};
	dopot_sync #(.W(SYNC_W)) u_sync (
		.clk(core_clk),
		.rstn(rstn),
		.sb(sync_bus)
	);
	logic scl_s, sda_s, tgl_s;
	logic [1:0] strap_s;
	assign scl_s = sync_bus.sync[4];
	assign sda_s = sync_bus.sync[3];
	assign tgl_s = sync_bus.sync[2];
	assign strap_s = sync_bus.sync[1:0];
	logic scl_d_q, sda_d_q, tgl_d_q;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			scl_d_q <= 1'b0;
			sda_d_q <= 1'b1;
			tgl_d_q <= 1'b0;
		end else begin
			scl_d_q <= scl_s;
			sda_d_q <= sda_s;
			tgl_d_q <= tgl_s;
		end
	end
	logic rise_ev, fall_ev, start_ev, stop_ev;
	assign rise_ev = tgl_s ^ tgl_d_q;
	assign fall_ev = scl_d_q & ~scl_s;
	assign start_ev = scl_s & scl_d_q & sda_d_q & ~sda_s;
	assign stop_ev = scl_s & scl_d_q & ~sda_d_q & sda_s;
	////////////////////////////////////////////////////////////////////////////
	// Own address
	logic [6:0] my_addr_q;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			my_addr_q <= ADDR_FIXED;
		end else begin
			my_addr_q <= USE_STRAPS ? {ADDR_UPPER, strap_s} : FIXED_ADDR;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Byte engine
	dopot_state_t state_q;
	logic [3:0] bitcnt_q;
	logic [7:0] sh_q, rd_sh_q, rd_byte;
	logic rd_idx_q, sda_oe_q, sel_q, ow_q;
	logic [1:0] sd_q, fstat_q;
	logic [7:0] wiper_q [2], save_q [2];
	logic [2:0] rd_pos;
	logic addr_hit, byte_done, instr_ev, wdata_ev, writable;
	assign addr_hit = (sh_q[7:1] == my_addr_q);
	assign byte_done = fall_ev && (bitcnt_q == CNT_ACK);
	assign instr_ev = byte_done && (state_q == ST_INSTR);
	assign wdata_ev = byte_done && (state_q == ST_WDATA);
	assign writable = (fstat_q != FUSE_DONE) || ow_q;
	assign rd_byte = rd_idx_q ? {fstat_q, VALID_PAD} : wiper_q[sel_q];
	assign rd_pos = 3'h7 - bitcnt_q[2:0];
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= ST_IDLE;
			bitcnt_q <= CNT_RST;
			sh_q <= BYTE_ZERO;
			rd_sh_q <= BYTE_ZERO;
			rd_idx_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else if (start_ev) begin
			state_q <= ST_ADDR;
			bitcnt_q <= CNT_RST;
			rd_idx_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else if (stop_ev) begin
			state_q <= ST_IDLE;
			bitcnt_q <= CNT_RST;
			sda_oe_q <= 1'b0;
		end else if (state_q != ST_IDLE) begin
			if (rise_ev) begin
				if (bitcnt_q == CNT_ACK) begin
					bitcnt_q <= CNT_DONE;
					if (state_q == ST_RDATA && link_bit_q) begin
						state_q <= ST_IDLE;
					end
				end else if (bitcnt_q != CNT_DONE) begin
					sh_q <= {sh_q[6:0], link_bit_q};
					bitcnt_q <= bitcnt_q + CNT_ONE;
				end
			end else if (fall_ev) begin
				if (bitcnt_q == CNT_ACK) begin
					unique case (state_q)
						ST_ADDR: begin
							if (addr_hit) begin
								sda_oe_q <= 1'b1;
								state_q <= sh_q[0] ? ST_RDATA : ST_INSTR;
							end else begin
								state_q <= ST_IDLE;
							end
						end
						ST_INSTR: begin
							sda_oe_q <= 1'b1;
							state_q <= ST_WDATA;
						end
						ST_WDATA: sda_oe_q <= 1'b1;
						ST_RDATA: sda_oe_q <= 1'b0;
						ST_IDLE: sda_oe_q <= 1'b0;
					endcase
				end else if (bitcnt_q == CNT_DONE) begin
					bitcnt_q <= CNT_RST;
					if (state_q == ST_RDATA) begin
						rd_sh_q <= rd_byte;
						sda_oe_q <= ~rd_byte[7];
						rd_idx_q <= ~rd_idx_q;
					end else begin
						sda_oe_q <= 1'b0;
					end
				end else if (state_q == ST_RDATA && bitcnt_q != CNT_RST) begin
					sda_oe_q <= ~rd_sh_q[rd_pos];
				end
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Instruction decode; bit 4 and bits 2..0 are not looked at
	logic fuse_prog_q;
	logic [7:0] fuse_val_q [2];
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sel_q <= 1'b0;
			sd_q <= 2'b00;
			ow_q <= 1'b0;
			fuse_prog_q <= 1'b0;
			fuse_val_q[0] <= BYTE_ZERO;
			fuse_val_q[1] <= BYTE_ZERO;
		end else begin
			fuse_prog_q <= 1'b0;
			if (instr_ev) begin
				sel_q <= sh_q[IB_SEL];
				sd_q[sh_q[IB_SEL]] <= sh_q[IB_SD];
				ow_q <= sh_q[IB_OW];
				if (sh_q[IB_OTP] && fstat_q != FUSE_DONE) begin
					fuse_prog_q <= 1'b1;
					fuse_val_q[0] <= wiper_q[0];
					fuse_val_q[1] <= wiper_q[1];
				end
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Wipers, power-up preset and override save
	logic init_q;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			init_q <= 1'b0;
		end else begin
			init_q <= 1'b1;
		end
	end
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			save_q[0] <= WIPER_MID;
			save_q[1] <= WIPER_MID;
		end else if (instr_ev && !ow_q && sh_q[IB_OW]) begin
			save_q[0] <= wiper_q[0];
			save_q[1] <= wiper_q[1];
		end
	end
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wiper_q[0] <= WIPER_MID;
			wiper_q[1] <= WIPER_MID;
		end else if (!init_q) begin
			if ({fuse_status_high, fuse_status_low} == FUSE_DONE) begin
				wiper_q[0] <= fused_setting_ch1;
				wiper_q[1] <= fused_setting_ch2;
			end else begin
				wiper_q[0] <= WIPER_MID;
				wiper_q[1] <= WIPER_MID;
			end
		end else if (instr_ev && ow_q && !sh_q[IB_OW]) begin
			wiper_q[0] <= save_q[0];
			wiper_q[1] <= save_q[1];
		end else if (wdata_ev && writable) begin
			wiper_q[sel_q] <= sh_q;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Fuse status follows the array until programming succeeded
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			fstat_q <= FUSE_READY;
		end else if (fstat_q != FUSE_DONE) begin
			fstat_q <= {fuse_status_high, fuse_status_low};
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign sda_o = 1'b0;
	assign sda_oe = sda_oe_q;
	assign fuse_prog = fuse_prog_q;
	assign fuse_prog_value_ch1 = fuse_val_q[0];
	assign fuse_prog_value_ch2 = fuse_val_q[1];
	assign variable_resistor_setting_ch1 = wiper_q[0];
	assign variable_resistor_setting_ch2 = wiper_q[1];
	assign shutdown_ch1 = sd_q[0];
	assign shutdown_ch2 = sd_q[1];
	assign fuse_state = fstat_q;
	////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);

	property p_start;
		start_ev |=> state_q == ST_ADDR && bitcnt_q == CNT_RST && !sda_oe_q;
	endproperty
	a_start: assert property (p_start) else $error("start not taken");
	property p_ack_hit;
		byte_done && state_q == ST_ADDR && addr_hit |=> sda_oe_q ##1 sda_oe_q;
	endproperty
	a_ack_hit: assert property (p_ack_hit) else $error("address not acked");
	property p_miss_idle;
		byte_done && state_q == ST_ADDR && !addr_hit |=> state_q == ST_IDLE && !sda_oe_q;
	endproperty
	a_miss_idle: assert property (p_miss_idle) else $error("foreign address acked");
	property p_stop;
		stop_ev |=> state_q == ST_IDLE && !sda_oe_q;
	endproperty
	a_stop: assert property (p_stop) else $error("stop not honoured");
	property p_change_low;
		$changed(sda_oe_q) && !$past(start_ev) && !$past(stop_ev) |-> !scl_s;
	endproperty
	a_change_low: assert property (p_change_low) else $error("data moved, clock high");
	property p_wr;
		wdata_ev && writable && !sel_q |=> wiper_q[0] == $past(sh_q);
	endproperty
	a_wr: assert property (p_wr) else $error("wiper one not loaded");
	property p_locked;
		wdata_ev && !writable |=> $stable(wiper_q[0]) && $stable(wiper_q[1]);
	endproperty
	a_locked: assert property (p_locked) else $error("fused wiper changed");
	property p_status_hold;
		fstat_q == FUSE_DONE |=> fstat_q == FUSE_DONE && !fuse_prog_q;
	endproperty
	a_status_hold: assert property (p_status_hold) else $error("status moved");
	property p_valid_byte;
		fall_ev && bitcnt_q == CNT_DONE && state_q == ST_RDATA && rd_idx_q
			|=> rd_sh_q == {$past(fstat_q), VALID_PAD};
	endproperty
	a_valid_byte: assert property (p_valid_byte) else $error("bad status byte");
	property p_nack;
		rise_ev && state_q == ST_RDATA && bitcnt_q == CNT_ACK && link_bit_q
			|=> state_q == ST_IDLE ##1 !sda_oe_q;
	endproperty
	a_nack: assert property (p_nack) else $error("no release on nack");
	property p_preset;
		$rose(init_q) |-> wiper_q[0] == (($past(fuse_status_high) && $past(fuse_status_low))
			? $past(fused_setting_ch1) : WIPER_MID);
	endproperty
	a_preset: assert property (p_preset) else $error("bad power-up preset");

	c_write: cover property (wdata_ev && writable);
	c_read_status: cover property (fall_ev && bitcnt_q == CNT_DONE && state_q == ST_RDATA && rd_idx_q);
	c_fuse: cover property (fuse_prog_q);
	c_nack: cover property (rise_ev && state_q == ST_RDATA && bitcnt_q == CNT_ACK && link_bit_q);
endmodule : dopot_target

//--- sim/dopot_bus_master.sv
/*
 * Bus controller model: start, stop, byte out, byte in.
 * Assumes the data wire is resolved outside with a pull-up.
 */
module dopot_bus_master (
	input wire logic core_clk,
	output logic scl_clk,
	output logic sda_low,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		scl_clk = 1'b1;
		sda_low = 1'b0;
	end
	task automatic tick();
		repeat (12) @(posedge core_clk);
	endtask : tick
	// Data moves only while the clock is low
	task automatic bit_io(input logic b, output logic r);
		sda_low <= ~b;
		tick();
		scl_clk <= 1'b1;
		tick();
		r = sda;
		scl_clk <= 1'b0;
		tick();
	endtask : bit_io
	task automatic start();
		sda_low <= 1'b0;
		tick();
		scl_clk <= 1'b1;
		tick();
		sda_low <= 1'b1;
		tick();
		scl_clk <= 1'b0;
		tick();
	endtask : start
	task automatic stop();
		sda_low <= 1'b1;
		tick();
		scl_clk <= 1'b1;
		tick();
		sda_low <= 1'b0;
		tick();
	endtask : stop
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask : wr_byte
	// Low acknowledge asks for more; high ends the read
	task automatic rd_byte(input logic more, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(~more, r);
	endtask : rd_byte
endmodule : dopot_bus_master

//--- sim/test_dopot_target.sv
/*
 * Self-checking bench of the two-wire potentiometer target.
 * Assumes the bus master model and the design's package.
 */
module test_dopot_target;
	timeunit 1ns;
	timeprecision 1ns;
	import dopot_pkg::*;
	localparam logic [6:0] ADR = {ADDR_UPPER, 2'h2};
	logic core_clk = 1'b0;
	logic rstn = 1'b1;
	logic fsh = 1'b0;
	logic fsl = 1'b0;
	logic scl, sda_low, sda_o, sda_oe, fuse_prog, sd1, sd2;
	logic [7:0] pv1, pv2, vr1, vr2;
	logic [1:0] fst;
	wire sda = !(sda_low || (sda_oe && !sda_o));
	int failures = 0;
	int checked = 0;
	int pulses = 0;
	always #20 core_clk = ~core_clk;
	always @(posedge core_clk) if (fuse_prog === 1'b1) pulses++;
	dopot_target #(.USE_STRAPS(1'b1)) dopot_target_inst (
		.core_clk(core_clk), .rstn(rstn), .scl_clk(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe(sda_oe),
		.strap_addr_bit1(1'b1), .strap_addr_bit0(1'b0),
		.fuse_status_high(fsh), .fuse_status_low(fsl),
		.fused_setting_ch1(8'h9a), .fused_setting_ch2(8'h65),
		.fuse_prog(fuse_prog), .fuse_prog_value_ch1(pv1), .fuse_prog_value_ch2(pv2),
		.variable_resistor_setting_ch1(vr1), .variable_resistor_setting_ch2(vr2),
		.shutdown_ch1(sd1), .shutdown_ch2(sd2), .fuse_state(fst)
	);
	dopot_bus_master dopot_bus_master_inst (
		.core_clk(core_clk), .scl_clk(scl), .sda_low(sda_low), .sda(sda)
	);
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic end_of_test();
		if (failures == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_of_test
	// Write frame: address, instruction, then n data bytes d, d+1, ...
	task automatic wr(input logic [7:0] ins, input logic [7:0] d, input int n);
		logic a;
		logic ok;
		dopot_bus_master_inst.start();
		dopot_bus_master_inst.wr_byte({ADR, 1'b0}, ok);
		dopot_bus_master_inst.wr_byte(ins, a);
		ok &= a;
		for (int i = 0; i < n; i++) begin
			dopot_bus_master_inst.wr_byte(d + 8'(i), a);
			ok &= a;
		end
		dopot_bus_master_inst.stop();
		chk("write acks", 8'h1, {7'h0, ok});
	endtask : wr
	// Read frame: wiper, status, wiper again, then not-acknowledge
	task automatic rd(input logic [7:0] ew, input logic [1:0] es);
		logic a;
		logic [7:0] d;
		dopot_bus_master_inst.start();
		dopot_bus_master_inst.wr_byte({ADR, 1'b1}, a);
		chk("read ack", 8'h1, {7'h0, a});
		dopot_bus_master_inst.rd_byte(1'b1, d);
		chk("wiper", ew, d);
		dopot_bus_master_inst.rd_byte(1'b1, d);
		chk("status", {es, 6'h00}, {d[7:6], 6'h00});
		dopot_bus_master_inst.rd_byte(1'b0, d);
		chk("wiper again", ew, d);
		chk("released", 8'h0, {7'h0, sda_oe});
		dopot_bus_master_inst.stop();
	endtask : rd
	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset(input logic [7:0] e1, input logic [7:0] e2, input logic [1:0] es);
		rstn <= 1'b0;
		repeat (20) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk("preset ch1", e1, vr1);
		chk("preset ch2", e2, vr2);
		chk("fuse state", {6'h0, es}, {6'h0, fst});
	endtask : t_reset
	task automatic t_addr();
		logic a;
		dopot_bus_master_inst.start();
		dopot_bus_master_inst.wr_byte({ADDR_FIXED, 1'b0}, a);
		dopot_bus_master_inst.stop();
		chk("foreign ack", 8'h0, {7'h0, a});
	endtask : t_addr
	task automatic t_write();
		wr(8'h07, 8'h5a, 2);
		chk("ch1 repeated", 8'h5b, vr1);
		chk("ch2 kept", WIPER_MID, vr2);
		wr(8'h80, 8'hc3, 1);
		chk("ch2 written", 8'hc3, vr2);
		rd(8'hc3, FUSE_READY);
	endtask : t_write
	task automatic t_abort();
		logic a;
		dopot_bus_master_inst.start();
		dopot_bus_master_inst.wr_byte({ADR, 1'b0}, a);
		dopot_bus_master_inst.wr_byte(8'h00, a);
		repeat (3) dopot_bus_master_inst.bit_io(1'b1, a);
		dopot_bus_master_inst.stop();
		chk("partial dropped", 8'h5b, vr1);
	endtask : t_abort
	task automatic t_shut();
		wr(8'hc0, 8'h11, 1);
		chk("shut ch2", 8'h1, {7'h0, sd2});
		chk("shut ch1", 8'h0, {7'h0, sd1});
		chk("stored in shutdown", 8'h11, vr2);
		wr(8'h80, 8'h00, 0);
		chk("shut released", 8'h0, {7'h0, sd2});
		chk("value kept", 8'h11, vr2);
	endtask : t_shut
	task automatic t_fuse();
		fsh <= 1'b1;
		rd(8'h11, FUSE_FAIL);
		fsh <= 1'b0;
		wr(8'h20, 8'h00, 0);
		chk("prog pulses", 8'h1, 8'(pulses));
		chk("prog value", 8'h5b, pv1);
		chk("prog value ch2", 8'h11, pv2);
		fsh <= 1'b1;
		fsl <= 1'b1;
		rd(8'h5b, FUSE_DONE);
		wr(8'h00, 8'h44, 1);
		chk("fused wiper", 8'h5b, vr1);
		wr(8'h20, 8'h00, 0);
		fsh <= 1'b0;
		fsl <= 1'b0;
		repeat (8) @(posedge core_clk);
		chk("no reprogram", 8'h1, 8'(pulses));
		chk("status frozen", 8'h3, {6'h0, fst});
	endtask : t_fuse
	task automatic t_over();
		wr(8'h08, 8'h77, 1);
		chk("override write", 8'h77, vr1);
		wr(8'h00, 8'h00, 0);
		chk("override restore", 8'h5b, vr1);
	endtask : t_over
	////////////////////////////////////////////////////////////////////////////
	initial begin
		t_reset(WIPER_MID, WIPER_MID, FUSE_READY);
		t_addr();
		t_write();
		t_abort();
		t_shut();
		t_fuse();
		t_over();
		fsh <= 1'b1;
		fsl <= 1'b1;
		t_reset(8'h9a, 8'h65, FUSE_DONE);
		end_of_test();
	end
	initial begin
		#2_000_000;
		failures++;
		end_of_test();
	end
endmodule : test_dopot_target
